// file: rtl/icsra_pkg.sv
// Package: offsets, field positions, reset values and counts for the indirect CSR window
package icsra_pkg;

  localparam logic [7:0]  WINDOW_OFFSET     = 8'h5C;
  localparam int          SEL_LSB           = 0;
  localparam int          SEL_W             = 6;
  localparam int          WRITE_FLAG_BIT    = 7;
  localparam int          WDATA_LSB         = 14;
  localparam int          WDATA_W           = 18;
  localparam int          OWN_BITS_W        = 14;

  localparam logic [5:0]  SEL_RANGE_ENABLE  = 6'h05;
  localparam logic [5:0]  SEL_DIAGNOSTIC    = 6'h06;
  localparam logic [5:0]  SEL_FAILING_DATA  = 6'h07;
  localparam logic [5:0]  SEL_OFFLEN_BASE   = 6'h20;

  localparam int          EXT_ENABLE_BIT    = 26;
  localparam int          STD_ENABLE_BIT    = 25;
  localparam int          OFFSET_LSB        = 20;
  localparam int          OFFSET_W          = 12;
  localparam int          ALEN_LSB          = 18;
  localparam int          DLEN_LSB          = 16;
  localparam int          HOST_ADDR_W       = 20;
  localparam int          OFFLEN_COUNT      = 32;
  localparam int          NODE_RESET_BIT    = 30;
  localparam int          LOCAL_INIT_BIT    = 22;

  localparam logic [31:0] RANGE_ENABLE_RST  = 32'h0000_0000;
  localparam logic [31:0] FAILING_DATA_RST  = 32'h0000_0000;
  localparam logic [31:0] OFFLEN_RST        = 32'h0000_0000;
  localparam logic [7:0]  WINDOW_RST        = 8'h00;

  localparam logic [1:0]  ALEN_EXTENDED     = 2'h0;
  localparam logic [1:0]  ALEN_INVALID      = 2'h1;
  localparam logic [1:0]  ALEN_SHORT        = 2'h2;
  localparam logic [1:0]  ALEN_STANDARD     = 2'h3;
  localparam logic [1:0]  DLEN_INVALID      = 2'h0;
  localparam logic [1:0]  DLEN_BYTE         = 2'h1;
  localparam logic [1:0]  DLEN_WORD         = 2'h2;
  localparam logic [1:0]  DLEN_LONG         = 2'h3;

  // Cycles SYSRESET* is held after initialization (arbitrary default, 200 ns)
  localparam int          SYSRESET_NS       = 200;
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          SYSRESET_CYCLES   = (SYSRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SYSRESET_CNT_RST  = 8'(SYSRESET_CYCLES);

  typedef enum logic [1:0] {
    ICSRA_SPACE_NONE,
    ICSRA_SPACE_SHORT,
    ICSRA_SPACE_STANDARD,
    ICSRA_SPACE_EXTENDED
  } icsra_space_type;

endpackage

// file: rtl/icsra_slave_gate.sv
// VME slave address-range acceptance gate
`timescale 1ns/1ps
module icsra_slave_gate (
  input  wire logic                         std_enable_i,
  input  wire logic                         ext_enable_i,
  input  wire icsra_pkg::icsra_space_type   space_i,
  input  wire logic [31:0]                  addr_i,
  input  wire logic                         am_valid_i,
  output logic                              accept_o
);

  always_comb
  begin
    accept_o = 1'b0;
    case (space_i)
      icsra_pkg::ICSRA_SPACE_EXTENDED:
        accept_o = ext_enable_i && (addr_i[31:29] == 3'h0) && am_valid_i;
      icsra_pkg::ICSRA_SPACE_STANDARD:
        accept_o = std_enable_i && !addr_i[23] && am_valid_i;
      default:
        accept_o = 1'b0;
    endcase
  end

endmodule // icsra_slave_gate

// file: rtl/icsra_top.sv
// Indirect CSR access window with range enable, failing data and offset/length registers
`timescale 1ns/1ps
module icsra_top (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rstn_i,
  input  wire logic                         win_wr_i,
  input  wire logic                         win_rd_i,
  input  wire logic [31:0]                  win_wdata_i,
  output logic      [31:0]                  win_rdata_o,
  input  wire logic                         bus_err_wr_i,
  input  wire logic [31:0]                  bus_err_wdata_i,
  input  wire logic                         dev_cfg_wr_i,
  input  wire logic [31:0]                  dev_cfg_wdata_i,
  input  wire logic [31:0]                  vme_data_i,
  input  wire logic                         timeout_i,
  input  wire logic                         timeout_clear_i,
  input  wire logic                         self_test_pass_i,
  input  wire logic                         slv_req_i,
  input  wire logic                         slv_is_host_i,
  input  wire icsra_pkg::icsra_space_type   slv_space_i,
  input  wire logic [31:0]                  slv_addr_i,
  input  wire logic                         slv_am_valid_i,
  output logic                              slv_accept_o,
  input  wire logic [4:0]                   host_sel_i,
  input  wire logic [19:0]                  host_addr_i,
  input  wire logic                         host_write_i,
  input  wire logic [3:0]                   host_mask_i,
  output logic [31:0]                       vme_addr_o,
  output icsra_pkg::icsra_space_type        vme_space_o,
  output logic [2:0]                        vme_size_o,
  output logic                              vme_cycle_ok_o,
  output logic                              self_test_fail_n_o,
  output logic                              sysreset_n_o,
  output logic                              local_init_o
);

  logic [7:0]   window_q;
  logic [31:0]  range_enable_q;
  logic [31:0]  failing_data_q;
  logic         frozen_q;
  logic [31:0]  offlen_q [0:icsra_pkg::OFFLEN_COUNT-1];
  logic [31:0]  rdata_q;
  logic         stf_n_q;
  logic [7:0]   sysreset_cnt_q;
  logic         local_init_q;
  logic [31:0]  vme_data_s1_q;
  logic [31:0]  vme_data_s2_q;
  logic         timeout_s1_q;
  logic         timeout_s2_q;
  logic         stp_s1_q;
  logic         stp_s2_q;
  logic         init_n;
  logic         node_reset;
  logic [5:0]   wsel;
  logic         wflag;
  logic [17:0]  wdata;
  logic [31:0]  sel_value;
  logic [31:0]  chosen;
  logic         slv_accept_raw;

  // Size in bytes as a 3-bit count from a byte mask
  function automatic logic [2:0] mask_bytes(input logic [3:0] m);
    mask_bytes = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  // Register contents for a select code; unmapped codes yield zero
  function automatic logic [31:0] sel_read(input logic [5:0] s,
                                           input logic [31:0] rng,
                                           input logic [31:0] fdr,
                                           input logic [31:0] ol);
    if (s == icsra_pkg::SEL_RANGE_ENABLE)
      sel_read = rng;
    else if (s == icsra_pkg::SEL_FAILING_DATA)
      sel_read = fdr;
    else if (s >= icsra_pkg::SEL_OFFLEN_BASE)
      sel_read = {ol[31:16], 16'h0000};
    else
      sel_read = 32'h0000_0000;
  endfunction

  assign node_reset = bus_err_wr_i && bus_err_wdata_i[icsra_pkg::NODE_RESET_BIT];
  assign init_n     = rstn_i && !node_reset;
  assign wsel       = win_wdata_i[icsra_pkg::SEL_LSB +: icsra_pkg::SEL_W];
  assign wflag      = win_wdata_i[icsra_pkg::WRITE_FLAG_BIT];
  assign wdata      = win_wdata_i[icsra_pkg::WDATA_LSB +: icsra_pkg::WDATA_W];

  always_ff @(posedge clk_sys_i)
  begin
    vme_data_s1_q <= vme_data_i;
    vme_data_s2_q <= vme_data_s1_q;
    timeout_s1_q  <= timeout_i;
    timeout_s2_q  <= timeout_s1_q;
    stp_s1_q      <= self_test_pass_i;
    stp_s2_q      <= stp_s1_q;
  end

  // Flag and select must come in the same write, so they are captured together
  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      window_q <= icsra_pkg::WINDOW_RST;
    else if (win_wr_i)
      window_q <= {wflag, 1'b0, wsel};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      range_enable_q <= icsra_pkg::RANGE_ENABLE_RST;
    else if (win_wr_i && wflag && wsel == icsra_pkg::SEL_RANGE_ENABLE)
      range_enable_q <= {wdata, 14'h0000};
  end

  genvar gi;
  generate
    for (gi = 0; gi < icsra_pkg::OFFLEN_COUNT; gi++)
    begin : g_offlen
      always_ff @(posedge clk_sys_i)
      begin
        if (!init_n)
          offlen_q[gi] <= icsra_pkg::OFFLEN_RST;
        else if (win_wr_i && wflag && wsel == (icsra_pkg::SEL_OFFLEN_BASE | 6'(gi)))
          offlen_q[gi] <= {wdata, 14'h0000};
      end
    end
  endgenerate

  // Timeout locks; a clear in the same cycle as a new timeout leaves it locked
  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      frozen_q <= 1'b0;
    else if (timeout_s2_q)
      frozen_q <= 1'b1;
    else if (timeout_clear_i)
      frozen_q <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      failing_data_q <= icsra_pkg::FAILING_DATA_RST;
    else if (!frozen_q && !timeout_s2_q)
      failing_data_q <= vme_data_s2_q;
  end

  assign sel_value = sel_read(window_q[5:0], range_enable_q, failing_data_q,
                              offlen_q[window_q[4:0]]);

  // Read data is registered for a one-cycle answer after the read strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      rdata_q <= 32'h0000_0000;
    else if (win_rd_i && window_q[icsra_pkg::WRITE_FLAG_BIT])
      rdata_q <= {sel_value[31:14], 6'h00, window_q};
    else if (win_rd_i)
      rdata_q <= sel_value;
  end

  assign win_rdata_o = rdata_q;

  icsra_slave_gate u_gate (
    .std_enable_i (range_enable_q[icsra_pkg::STD_ENABLE_BIT]),
    .ext_enable_i (range_enable_q[icsra_pkg::EXT_ENABLE_BIT]),
    .space_i      (slv_space_i),
    .addr_i       (slv_addr_i),
    .am_valid_i   (slv_am_valid_i),
    .accept_o     (slv_accept_raw)
  );

  // Host-originated cycles never pass the range gate, whatever the enables say
  assign slv_accept_o = slv_req_i && !slv_is_host_i && slv_accept_raw;

  assign chosen = offlen_q[host_sel_i];

  always_comb
  begin
    vme_addr_o     = {chosen[icsra_pkg::OFFSET_LSB +: icsra_pkg::OFFSET_W], host_addr_i};
    vme_cycle_ok_o = 1'b1;
    case (chosen[icsra_pkg::ALEN_LSB +: 2])
      icsra_pkg::ALEN_EXTENDED: vme_space_o = icsra_pkg::ICSRA_SPACE_EXTENDED;
      icsra_pkg::ALEN_STANDARD: vme_space_o = icsra_pkg::ICSRA_SPACE_STANDARD;
      icsra_pkg::ALEN_SHORT:
      begin
        vme_space_o    = icsra_pkg::ICSRA_SPACE_SHORT;
        vme_cycle_ok_o = 1'b0;
      end
      default:
      begin
        vme_space_o    = icsra_pkg::ICSRA_SPACE_NONE;
        vme_cycle_ok_o = 1'b0;
      end
    endcase
    if (host_write_i)
    begin
      vme_size_o = mask_bytes(host_mask_i);
      if (host_mask_i == 4'h0)
        vme_cycle_ok_o = 1'b0;
    end
    else
    begin
      case (chosen[icsra_pkg::DLEN_LSB +: 2])
        icsra_pkg::DLEN_BYTE: vme_size_o = 3'h1;
        icsra_pkg::DLEN_WORD: vme_size_o = 3'h2;
        icsra_pkg::DLEN_LONG: vme_size_o = 3'h4;
        default:
        begin
          vme_size_o     = 3'h0;
          vme_cycle_ok_o = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      stf_n_q <= 1'b0;
    else if (stp_s2_q)
      stf_n_q <= 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      sysreset_cnt_q <= icsra_pkg::SYSRESET_CNT_RST;
    else if (sysreset_cnt_q != 8'h00)
      sysreset_cnt_q <= sysreset_cnt_q - 8'h01;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!init_n)
      local_init_q <= 1'b0;
    else
      local_init_q <= dev_cfg_wr_i && dev_cfg_wdata_i[icsra_pkg::LOCAL_INIT_BIT];
  end

  assign self_test_fail_n_o = stf_n_q;
  assign sysreset_n_o       = (sysreset_cnt_q == 8'h00);
  assign local_init_o       = local_init_q;

endmodule // icsra_top

// file: test/icsra_host_model.sv
// Host CPU model that drives the window strobes
`timescale 1ns/1ps
module icsra_host_model (
  input  wire logic  clk_sys_i,
  output logic       win_wr_o = 1'b0,
  output logic       win_rd_o = 1'b0,
  output logic [31:0] win_wdata_o = 32'h0
);
  // Flag, select and data always go out together in one write
  task automatic wr(input logic [31:0] dat);
    win_wr_o <= 1'b1;
    win_rd_o <= 1'b0;
    win_wdata_o <= dat;
    @(posedge clk_sys_i);
  endtask
  // Read or idle; released data lines toggle so stale data is never seen
  task automatic op(input logic rd);
    win_wr_o <= 1'b0;
    win_rd_o <= rd;
    win_wdata_o <= ~win_wdata_o;
    @(posedge clk_sys_i);
  endtask
endmodule // icsra_host_model

// file: test/icsra_top_assertions.sv
// Port checker for the indirect CSR window block
`timescale 1ns/1ps
module icsra_top_chk (
  input wire logic                       clk_sys_i,
  input wire logic                       rstn_i,
  input wire logic                       win_wr_i,
  input wire logic                       win_rd_i,
  input wire logic [31:0]                win_wdata_i,
  input wire logic [31:0]                win_rdata_o,
  input wire logic                       bus_err_wr_i,
  input wire logic [31:0]                bus_err_wdata_i,
  input wire logic                       dev_cfg_wr_i,
  input wire logic [31:0]                dev_cfg_wdata_i,
  input wire icsra_pkg::icsra_space_type slv_space_i,
  input wire logic                       slv_accept_o,
  input wire logic [19:0]                host_addr_i,
  input wire logic [31:0]                vme_addr_o,
  input wire logic                       self_test_fail_n_o,
  input wire logic                       sysreset_n_o,
  input wire logic                       local_init_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  // Node reset may also clear read data, so it and local init end the hold
  wire quiet = rstn_i && !(bus_err_wr_i && bus_err_wdata_i[30])
               && !(dev_cfg_wr_i && dev_cfg_wdata_i[22]);
  a_reset_rdata: assert property (!rstn_i |=> win_rdata_o == 32'h0)
    else $error("read data not cleared by reset");
  a_stf_reset: assert property (!rstn_i |=> !self_test_fail_n_o)
    else $error("self test fail not driven in reset");
  a_sysrst_reset: assert property (!rstn_i |=> !sysreset_n_o)
    else $error("backplane reset not driven in reset");
  a_sysrst_hold: assert property ($rose(rstn_i) |-> (!sysreset_n_o) [*8])
    else $error("backplane reset released too early");
  a_host_addr: assert property (disable iff (!rstn_i) vme_addr_o[19:0] == host_addr_i)
    else $error("host address bits not passed through");
  a_short_refuse: assert property (disable iff (!rstn_i)
    slv_space_i == icsra_pkg::ICSRA_SPACE_SHORT |-> !slv_accept_o)
    else $error("short address cycle accepted");
  a_win_hold: assert property (disable iff (!rstn_i)
    quiet && !win_rd_i |=> $stable(win_rdata_o))
    else $error("read data changed without a read");
  a_local_init: assert property (disable iff (!rstn_i)
    dev_cfg_wr_i && dev_cfg_wdata_i[22] |=> local_init_o)
    else $error("local init pulse missing");
  a_unmapped_read: assert property (disable iff (!rstn_i)
    win_wr_i && win_wdata_i[7:0] == 8'h00 ##1 win_rd_i |=> win_rdata_o == 32'h0)
    else $error("unmapped select read not zero");
  c_read: cover property (win_rd_i ##1 win_rdata_o != 32'h0);
  c_accept: cover property (slv_accept_o);
  c_init: cover property (local_init_o);
endmodule // icsra_top_chk

bind icsra_top icsra_top_chk u_chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .win_wr_i(win_wr_i), .win_rd_i(win_rd_i),
  .win_wdata_i(win_wdata_i), .win_rdata_o(win_rdata_o), .bus_err_wr_i(bus_err_wr_i),
  .bus_err_wdata_i(bus_err_wdata_i), .dev_cfg_wr_i(dev_cfg_wr_i),
  .dev_cfg_wdata_i(dev_cfg_wdata_i), .slv_space_i(slv_space_i),
  .slv_accept_o(slv_accept_o), .host_addr_i(host_addr_i), .vme_addr_o(vme_addr_o),
  .self_test_fail_n_o(self_test_fail_n_o), .sysreset_n_o(sysreset_n_o),
  .local_init_o(local_init_o)
);

// file: test/icsra_top_bench.sv
// Self-checking bench for the indirect CSR window block
`timescale 1ns/1ps
module icsra_top_bench;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, win_wr_i, win_rd_i, slv_accept_o, vme_cycle_ok_o;
  logic bus_err_wr_i = 1'b0, dev_cfg_wr_i = 1'b0, timeout_i = 1'b0, timeout_clear_i = 1'b0;
  logic self_test_pass_i = 1'b0, slv_req_i = 1'b0, slv_is_host_i = 1'b0, slv_am_valid_i = 1'b0;
  logic host_write_i = 1'b0, self_test_fail_n_o, sysreset_n_o, local_init_o, rd_pend = 1'b0;
  logic [31:0] win_wdata_i, win_rdata_o, vme_addr_o, v, bus_err_wdata_i = 32'h0, exp_q[$];
  logic [31:0] dev_cfg_wdata_i = 32'h0, vme_data_i = 32'h0, slv_addr_i = 32'h0;
  logic [19:0] host_addr_i = 20'h0;
  logic [4:0]  host_sel_i = 5'h0;
  logic [3:0]  host_mask_i = 4'h0;
  logic [2:0]  vme_size_o;
  logic [17:0] d, ol[32];
  icsra_pkg::icsra_space_type slv_space_i = icsra_pkg::ICSRA_SPACE_NONE, vme_space_o;
  int seed = 78831, bad_count = 0, check_count = 0, cyc = 0;

  icsra_top DUT (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .win_wr_i(win_wr_i), .win_rd_i(win_rd_i),
    .win_wdata_i(win_wdata_i), .win_rdata_o(win_rdata_o), .bus_err_wr_i(bus_err_wr_i),
    .bus_err_wdata_i(bus_err_wdata_i), .dev_cfg_wr_i(dev_cfg_wr_i),
    .dev_cfg_wdata_i(dev_cfg_wdata_i), .vme_data_i(vme_data_i), .timeout_i(timeout_i),
    .timeout_clear_i(timeout_clear_i), .self_test_pass_i(self_test_pass_i),
    .slv_req_i(slv_req_i), .slv_is_host_i(slv_is_host_i), .slv_space_i(slv_space_i),
    .slv_addr_i(slv_addr_i), .slv_am_valid_i(slv_am_valid_i), .slv_accept_o(slv_accept_o),
    .host_sel_i(host_sel_i), .host_addr_i(host_addr_i), .host_write_i(host_write_i),
    .host_mask_i(host_mask_i), .vme_addr_o(vme_addr_o), .vme_space_o(vme_space_o),
    .vme_size_o(vme_size_o), .vme_cycle_ok_o(vme_cycle_ok_o),
    .self_test_fail_n_o(self_test_fail_n_o), .sysreset_n_o(sysreset_n_o),
    .local_init_o(local_init_o)
  );
  icsra_host_model host (.clk_sys_i(clk_sys_i), .win_wr_o(win_wr_i), .win_rd_o(win_rd_i),
                         .win_wdata_o(win_wdata_i));

  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wsel(input logic [5:0] c, input logic [17:0] val);
    host.wr({val, 6'h00, 1'b1, 1'b0, c});
  endtask
  // Flag-clear select write, then the read whose answer is queued
  task automatic rsel(input logic [5:0] c, input logic [31:0] e);
    host.wr({24'h0, 2'b00, c});
    exp_q.push_back(e);
    host.op(1'b1);
    host.op(1'b0);
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (rd_pend)
      check(win_rdata_o, exp_q.pop_front());
    rd_pend <= win_rd_i;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    tick(12);
    rstn_i <= 1'b1;
    tick(1);
    check(32'(sysreset_n_o), 32'h0);
    check(32'(self_test_fail_n_o), 32'h0);
    rsel(6'h05, 32'h0);
    rsel(6'h00, 32'h0);
    d = 18'(rnd());
    wsel(6'h05, d);
    exp_q.push_back({d, 6'h00, 8'h85});
    host.op(1'b1);
    rsel(6'h05, {d, 14'h0});
    wsel(6'h06, 18'(rnd()));
    wsel(6'h1F, 18'(rnd()));
    rsel(6'h05, {d, 14'h0});
    for (int k = 0; k < 32; k++)
      ol[k] = {12'(rnd()), k[3:0], 2'(rnd())};
    for (int k = 0; k < 32; k++)
      wsel(6'h20 + 6'(k), ol[k]);
    for (int k = 0; k < 32; k++)
    begin
      rsel(6'h20 + 6'(k), {ol[k][17:2], 16'h0});
      host_sel_i <= 5'(k);
      host_addr_i <= 20'(rnd());
      tick(1);
      check(vme_addr_o, {ol[k][17:6], host_addr_i});
      // Space enum counts NONE, SHORT, STANDARD, EXTENDED from zero
      check(32'(vme_space_o), 32'(2'(ol[k][5:4] - 2'h1)));
      if (ol[k][3:2] != 2'h0)
        check(32'(vme_size_o), ol[k][3:2] == 2'h3 ? 32'h4 : 32'(ol[k][3:2]));
      v = 32'((ol[k][5:4] == 2'h0 || ol[k][5:4] == 2'h3) && ol[k][3:2] != 2'h0);
      check(32'(vme_cycle_ok_o), v);
    end
    host_write_i <= 1'b1;
    for (int k = 1; k < 16; k++)
    begin
      host_mask_i <= 4'(k);
      tick(1);
      check(32'(vme_size_o), 32'($countones(k)));
    end
    for (int k = 0; k < 4; k++)
    begin
      d = 18'(k) << 11;
      wsel(6'h05, d);
      host.op(1'b0);
      repeat (24)
      begin
        slv_req_i <= 1'(rnd() % 8 != 0);
        slv_is_host_i <= 1'(rnd() % 8 == 0);
        slv_space_i <= icsra_pkg::icsra_space_type'(2'(rnd()));
        slv_addr_i <= rnd() >> rnd() % 4;
        slv_am_valid_i <= 1'(rnd());
        tick(1);
        v = 32'(slv_req_i && !slv_is_host_i && slv_am_valid_i
            && ((slv_space_i == icsra_pkg::ICSRA_SPACE_EXTENDED && d[12]
            && slv_addr_i[31:29] == 3'h0) || (slv_space_i == icsra_pkg::ICSRA_SPACE_STANDARD
            && d[11] && !slv_addr_i[23])));
        check(32'(slv_accept_o), v);
      end
    end
    v = rnd();
    vme_data_i <= v;
    tick(4);
    timeout_i <= 1'b1;
    tick(4);
    vme_data_i <= ~v;
    tick(4);
    rsel(6'h07, v);
    timeout_i <= 1'b0;
    tick(4);
    timeout_clear_i <= 1'b1;
    tick(1);
    timeout_clear_i <= 1'b0;
    tick(4);
    rsel(6'h07, ~v);
    self_test_pass_i <= 1'b1;
    tick(5);
    check(32'(self_test_fail_n_o), 32'h1);
    check(32'(sysreset_n_o), 32'h1);
    bus_err_wdata_i <= 32'h4000_0000;
    bus_err_wr_i <= 1'b1;
    tick(1);
    bus_err_wr_i <= 1'b0;
    tick(1);
    check(32'(sysreset_n_o), 32'h0);
    rsel(6'h05, 32'h0);
    rsel(6'h3F, 32'h0);
    dev_cfg_wdata_i <= 32'h0040_0000;
    dev_cfg_wr_i <= 1'b1;
    tick(1);
    dev_cfg_wr_i <= 1'b0;
    tick(1);
    check(32'(local_init_o), 32'h1);
    tick(2);
    end_of_test();
  end
endmodule // icsra_top_bench
